// [psld_program_status_led_driver.sv]
`timescale 1ns/100ps

module psld_program_status_led_driver #(
    parameter int unsigned SLOW_BLINK_CYCLES   = psld_pkg::SLOW_BLINK_CYCLES,
    parameter int unsigned LEGACY_BLINK_CYCLES = psld_pkg::LEGACY_BLINK_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire psld_pkg::psld_ctrl_s    ctrl,
    input  wire psld_pkg::psld_axi_req_s axiReq,
    output      psld_pkg::psld_axi_rsp_s axiRsp,
    output      psld_pkg::psld_led_s     leds
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        psld_pkg::psld_led_s        leds;
        logic [psld_pkg::CNT_W-1:0] slowCnt;
        logic                       slowPhase;
        logic [psld_pkg::CNT_W-1:0] legacyCnt;
        logic                       legacyPhase;
        logic                       schemeNew;
        logic                       awHeld;
        logic [psld_pkg::ADDR_W-1:0] awAddr;
        logic                       wHeld;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        logic                       awReady;
        logic                       wReady;
        logic                       bValid;
        logic [1:0]                 bResp;
        logic                       arReady;
        logic                       rValid;
        logic [31:0]                rData;
        logic [1:0]                 rResp;
    } psld_state_s;

    psld_state_s st_q;
    psld_state_s st_d;

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    function automatic logic [31:0] readWord(
        input logic [psld_pkg::ADDR_W-1:0] addr,
        input psld_state_s                 s,
        input psld_pkg::psld_ctrl_s        c
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case ({addr[psld_pkg::ADDR_W-1:2], 2'h0})
            psld_pkg::CTRL_OFF: begin
                w[psld_pkg::CTRL_SCHEME_BIT] = s.schemeNew;
            end
            psld_pkg::STATUS_OFF: begin
                w[6:0] = s.leds;
                w[psld_pkg::STATUS_PHASE_BIT] = s.schemeNew ? s.slowPhase
                                                            : s.legacyPhase;
            end
            psld_pkg::INPUTS_OFF: begin
                w[$bits(c)-1:0] = c;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction : readWord

    function automatic logic addrMapped(
        input logic [psld_pkg::ADDR_W-1:0] addr
    );
        logic [7:0] a;
        a = {addr[psld_pkg::ADDR_W-1:2], 2'h0};
        return (a == psld_pkg::CTRL_OFF) || (a == psld_pkg::STATUS_OFF) ||
               (a == psld_pkg::INPUTS_OFF);
    endfunction : addrMapped

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic                blink;
        logic                legBlink;
        logic                doWrite;
        psld_pkg::psld_led_s l;
        blink    = 1'b0;
        legBlink = 1'b0;
        doWrite  = 1'b0;
        l        = '0;
        st_d     = st_q;

        if (ce) begin
            // Phase generators run freely so that every indicator sharing
            // a pattern blinks in step with the others.
            if (st_q.slowCnt == psld_pkg::CNT_W'(SLOW_BLINK_CYCLES - 1)) begin
                st_d.slowCnt   = '0;
                st_d.slowPhase = ~st_q.slowPhase;
            end else begin
                st_d.slowCnt = st_q.slowCnt + psld_pkg::CNT_W'(1);
            end
            if (st_q.legacyCnt ==
                psld_pkg::CNT_W'(LEGACY_BLINK_CYCLES - 1)) begin
                st_d.legacyCnt   = '0;
                st_d.legacyPhase = ~st_q.legacyPhase;
            end else begin
                st_d.legacyCnt = st_q.legacyCnt + psld_pkg::CNT_W'(1);
            end

            // Write channel: address and data are taken independently.
            if (axiReq.awvalid && st_q.awReady) begin
                st_d.awHeld = 1'b1;
                st_d.awAddr = axiReq.awaddr;
            end
            if (axiReq.wvalid && st_q.wReady) begin
                st_d.wHeld = 1'b1;
                st_d.wData = axiReq.wdata;
                st_d.wStrb = axiReq.wstrb;
            end
            if (st_q.bValid && axiReq.bready) begin
                st_d.bValid = 1'b0;
            end
            doWrite = st_q.awHeld && st_q.wHeld && !st_q.bValid;
            if (doWrite) begin
                st_d.awHeld = 1'b0;
                st_d.wHeld  = 1'b0;
                st_d.bValid = 1'b1;
                st_d.bResp  = addrMapped(st_q.awAddr) ? psld_pkg::RESP_OKAY
                                                      : psld_pkg::RESP_SLVERR;
                if ({st_q.awAddr[psld_pkg::ADDR_W-1:2], 2'h0} ==
                    psld_pkg::CTRL_OFF && st_q.wStrb[0]) begin
                    st_d.schemeNew =
                        st_q.wData[psld_pkg::CTRL_SCHEME_BIT];
                end
            end
            st_d.awReady = !st_d.awHeld && !st_d.bValid;
            st_d.wReady  = !st_d.wHeld && !st_d.bValid;

            // Read channel: one read at a time, answered the next cycle.
            if (st_q.rValid && axiReq.rready) begin
                st_d.rValid = 1'b0;
            end
            if (axiReq.arvalid && st_q.arReady) begin
                st_d.rValid = 1'b1;
                st_d.rData  = readWord(axiReq.araddr, st_q, ctrl);
                st_d.rResp  = addrMapped(axiReq.araddr) ? psld_pkg::RESP_OKAY
                                                        : psld_pkg::RESP_SLVERR;
            end
            st_d.arReady = !st_d.rValid;

            // Indicator mapping. Each lamp with both a blink and a steady source is
            // blink ? phase : steady, so there a blink condition always masks a steady one.
            blink    = st_q.slowPhase;
            legBlink = st_q.legacyPhase;
            if (ctrl.booting) begin
                l = '1;
            end else if (st_q.schemeNew) begin
                l.runIndicator = (ctrl.operateState || ctrl.firmwareLoading)
                               ? blink : ctrl.runState;
                l.stopIndicator = ((ctrl.stopState && !ctrl.configValid) ||
                                   ctrl.firmwareLoading)
                                ? blink
                                : (ctrl.stopState && ctrl.configValid);
                l.loadIndicator = ctrl.configLoading || ctrl.firmwareLoading ||
                                  ctrl.watchdogTimeSettingChange ||
                                  ctrl.safetyParameterSettingChange;
                l.faultIndicator = (ctrl.firmwareCorrupt ||
                                    ctrl.firmwareLoadFail ||
                                    !ctrl.configValid)
                                 ? blink : ctrl.ioFault;
                l.forceIndicator = ctrl.forceActive ? blink
                                 : (ctrl.forcePrepared &&
                                    (ctrl.runState || ctrl.stopState));
                l.emergencyLoaderIndicator = ctrl.emergencyLoaderActive &&
                                             blink;
                l.bootLoaderIndicator = (ctrl.imagesDefective ||
                                         ctrl.initHwFault ||
                                         ctrl.processDataFail) && blink;
            end else begin
                l.runIndicator = ctrl.runState;
                l.stopIndicator = ctrl.stopState && !ctrl.runState &&
                                  !ctrl.firmwareLoading;
                l.loadIndicator = (ctrl.initToStop || ctrl.firmwareFlashWrite)
                                ? legBlink : ctrl.configLoading;
                l.faultIndicator = (ctrl.firmwareLoadFail || ctrl.ioFault)
                                 ? legBlink
                                 : (!ctrl.configValid ||
                                    ctrl.firmwareCorrupt);
                l.forceIndicator = (ctrl.runState && ctrl.forceActive) ||
                                   (ctrl.stopState && ctrl.forcePrepared);
                l.emergencyLoaderIndicator = ctrl.emergencyLoaderActive &&
                                             legBlink;
                l.bootLoaderIndicator = (ctrl.imagesDefective ||
                                         ctrl.initHwFault) && legBlink;
            end
            st_d.leds = l;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q           <= '0;
            st_q.schemeNew <= psld_pkg::SCHEME_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign leds           = st_q.leds;
    assign axiRsp.awready = st_q.awReady;
    assign axiRsp.wready  = st_q.wReady;
    assign axiRsp.bvalid  = st_q.bValid;
    assign axiRsp.bresp   = st_q.bResp;
    assign axiRsp.arready = st_q.arReady;
    assign axiRsp.rvalid  = st_q.rValid;
    assign axiRsp.rdata   = st_q.rData;
    assign axiRsp.rresp   = st_q.rResp;

endmodule : psld_program_status_led_driver

// [psld_pkg.sv]
package psld_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ             = 250_000_000;
    localparam int unsigned SLOW_BLINK_PHASE_MS = 600;
    localparam int unsigned LEGACY_BLINK_PHASE_MS = 300;
    localparam int unsigned SLOW_BLINK_CYCLES  =
        (CLK_HZ / 1000) * SLOW_BLINK_PHASE_MS;
    localparam int unsigned LEGACY_BLINK_CYCLES =
        (CLK_HZ / 1000) * LEGACY_BLINK_PHASE_MS;
    localparam int unsigned CNT_W              = 28;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  CTRL_OFF    = 8'h00;
    localparam logic [7:0]  STATUS_OFF  = 8'h04;
    localparam logic [7:0]  INPUTS_OFF  = 8'h08;
    localparam int unsigned CTRL_SCHEME_BIT   = 0;
    localparam int unsigned STATUS_PHASE_BIT  = 7;
    localparam logic        SCHEME_RESET      = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic booting;
        logic runState;
        logic operateState;
        logic stopState;
        logic configValid;
        logic configLoading;
        logic firmwareLoading;
        logic firmwareFlashWrite;
        logic initToStop;
        logic watchdogTimeSettingChange;
        logic safetyParameterSettingChange;
        logic firmwareCorrupt;
        logic firmwareLoadFail;
        logic ioFault;
        logic forcePrepared;
        logic forceActive;
        logic emergencyLoaderActive;
        logic imagesDefective;
        logic initHwFault;
        logic processDataFail;
    } psld_ctrl_s;

    typedef struct packed {
        logic runIndicator;
        logic stopIndicator;
        logic loadIndicator;
        logic faultIndicator;
        logic forceIndicator;
        logic emergencyLoaderIndicator;
        logic bootLoaderIndicator;
    } psld_led_s;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } psld_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } psld_axi_rsp_s;

endpackage : psld_pkg

// [psld_checker.sv]
`timescale 1ns/100ps
module psld_checker #(
    parameter int unsigned SLOW_BLINK_CYCLES   = 4,
    parameter int unsigned LEGACY_BLINK_CYCLES = 6
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    ce,
    input wire psld_pkg::psld_ctrl_s    ctrl,
    input wire psld_pkg::psld_axi_req_s axiReq,
    input wire psld_pkg::psld_axi_rsp_s axiRsp,
    input wire psld_pkg::psld_led_s     leds
);
    localparam int unsigned MAXP = SLOW_BLINK_CYCLES > LEGACY_BLINK_CYCLES
        ? SLOW_BLINK_CYCLES : LEGACY_BLINK_CYCLES;
    logic [1:0]  warm_q;
    logic [31:0] elOn_q;
    logic        live;
    logic        elLive;
    logic        elLamp;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    assign live   = warm_q == 2'h3;
    assign elLamp = leds.emergencyLoaderIndicator;
    assign elLive = ce && ctrl.emergencyLoaderActive && !ctrl.booting;

    // All lamps lit means booting, which may hold this lamp on for long.
    always_ff @(posedge clk) begin
        warm_q <= rst ? 2'h0 : warm_q + {1'b0, !live};
        elOn_q <= (rst || !ce || !elLamp || &leds) ? 32'h0 : elOn_q + 32'h1;
    end

    sequence s_wr_taken;
        ce && axiReq.awvalid && axiRsp.awready && axiReq.wvalid
            && axiRsp.wready;
    endsequence
    sequence s_rd_taken;
        ce && axiReq.arvalid && axiRsp.arready;
    endsequence

    AST_BOOT_ALL_ON: assert property (
        live && ce && ctrl.booting |=> &leds) else $error("not all lit");
    AST_RUN_STEADY: assert property (
        live && ce && ctrl.runState && !ctrl.operateState
        && !ctrl.firmwareLoading && !ctrl.booting |=> leds.runIndicator)
        else $error("run lamp not lit");
    AST_RUN_OFF: assert property (
        live && ce && !ctrl.runState && !ctrl.operateState
        && !ctrl.firmwareLoading && !ctrl.booting |=> !leds.runIndicator)
        else $error("run lamp lit");
    AST_EL_OFF: assert property (
        live && ce && !ctrl.booting && !ctrl.emergencyLoaderActive
        |=> !elLamp) else $error("loader lamp lit");
    AST_EL_PHASE_MIN: assert property (
        (live && $rose(elLamp) && $past(elLive) && $past(elLive, 2))
        ##0 elLive [*3] |-> elLamp) else $error("blink phase short");
    AST_EL_PHASE_MAX: assert property (
        elOn_q <= MAXP) else $error("blink phase long");
    AST_READ_ANSWER: assert property (
        s_rd_taken |=> axiRsp.rvalid) else $error("read not answered");
    AST_WRITE_ANSWER: assert property (
        s_wr_taken ##1 ce |=> axiRsp.bvalid) else $error("no write answer");
    AST_READ_HOLD: assert property (
        axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid
        && $stable(axiRsp.rdata)) else $error("read data dropped");
    AST_RD_UNMAPPED: assert property (
        s_rd_taken ##0 axiReq.araddr >= 8'h0C |=> axiRsp.rdata == 32'h0
        && axiRsp.rresp == psld_pkg::RESP_SLVERR) else $error("bad read ok");
    AST_FREEZE: assert property (
        !ce |=> $stable(leds)) else $error("lamps moved while frozen");
endmodule : psld_checker

// [psld_lamp_panel.sv]
`timescale 1ns/100ps
module psld_lamp_panel (
    input  wire logic                clk,
    input  wire logic                clr,
    input  wire psld_pkg::psld_led_s leds,
    output logic [6:0][7:0]          litCount
);
    // An operator judges lit time, so each lamp counts its lit cycles.
    always_ff @(posedge clk) begin
        for (int i = 0; i < 7; i++) begin
            litCount[i] <= clr ? 8'h00 : litCount[i] + {7'h00, leds[i]};
        end
    end
endmodule : psld_lamp_panel

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
    localparam int unsigned SLOW = 4;
    localparam int unsigned LEG  = 6;
    localparam logic [19:0] BASE = 20'h08000;
    logic                    clk    = 1'b0;
    logic                    rst    = 1'b1;
    logic                    ce     = 1'b1;
    logic                    clr    = 1'b0;
    psld_pkg::psld_ctrl_s    ctrl   = '0;
    psld_pkg::psld_axi_req_s axiReq = '0;
    psld_pkg::psld_axi_rsp_s axiRsp;
    psld_pkg::psld_led_s     leds;
    logic [6:0][7:0]         lit;
    logic [31:0]             q;
    logic [1:0]              r;
    int                      per    = SLOW;
    int                      n_fail = 0;
    int                      checks = 0;

    always #2 clk = ~clk;

    psld_program_status_led_driver #(
        .SLOW_BLINK_CYCLES(SLOW),
        .LEGACY_BLINK_CYCLES(LEG)
    ) uut (
        .clk(clk), .rst(rst), .ce(ce), .ctrl(ctrl), .axiReq(axiReq),
        .axiRsp(axiRsp), .leds(leds)
    );
    psld_lamp_panel panel (.clk(clk), .clr(clr), .leds(leds), .litCount(lit));

    task results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    task chk(input string n, input logic [33:0] e, input logic [33:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    // A blinking lamp is lit for exactly half of any two-phase window.
    task tc(input logic [19:0] m, input logic [6:0] on, input logic [6:0] bl);
        logic [6:0] so, sb;
        ctrl <= psld_pkg::psld_ctrl_s'(BASE ^ m);
        repeat (3) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2 * per) @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < 7; i++) begin
            so[i] = lit[i] == 8'(2 * per);
            sb[i] = lit[i] == 8'(per);
        end
        chk("lamps", {20'h0, on, bl}, {20'h0, so, sb});
        @(posedge clk);
    endtask : tc

    task bus(input logic we, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] s);
        logic aw, w, ar, v, fin;
        fin = 1'b0;
        axiReq.awaddr  <= a;
        axiReq.araddr  <= a;
        axiReq.wdata   <= d;
        axiReq.wstrb   <= s;
        axiReq.awvalid <= we;
        axiReq.wvalid  <= we;
        axiReq.arvalid <= !we;
        for (int i = 0; i < 40 && !fin; i++) begin
            @(negedge clk);
            aw  = axiReq.awvalid & axiRsp.awready;
            w   = axiReq.wvalid & axiRsp.wready;
            ar  = axiReq.arvalid & axiRsp.arready;
            v   = we ? axiRsp.bvalid : axiRsp.rvalid;
            fin = (v & (we ? axiReq.bready : axiReq.rready)) === 1'b1;
            q   = axiRsp.rdata;
            r   = we ? axiRsp.bresp : axiRsp.rresp;
            @(posedge clk);
            if (aw) axiReq.awvalid <= 1'b0;
            if (w) axiReq.wvalid <= 1'b0;
            if (ar) axiReq.arvalid <= 1'b0;
            axiReq.bready <= we & v & !fin;
            axiReq.rready <= !we & v & !fin;
        end
        if (!fin) begin
            n_fail++;
            results();
        end
    endtask : bus

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, psld_pkg::CTRL_OFF, 32'h0, 4'h0);
        chk("ctrl", {33'h0, psld_pkg::SCHEME_RESET}, {r, q});
        bus(1'b0, 8'h0C, 32'h0, 4'h0);
        chk("rd bad", {psld_pkg::RESP_SLVERR, 32'h0}, {r, q});
        bus(1'b1, 8'h10, 32'h0, 4'hF);
        chk("wr bad", {psld_pkg::RESP_SLVERR, 32'h0}, {r, 32'h0});
        bus(1'b1, psld_pkg::CTRL_OFF, 32'h0, 4'h0);
        chk("wr lane", {psld_pkg::RESP_OKAY, 32'h0}, {r, 32'h0});
        bus(1'b1, psld_pkg::STATUS_OFF, 32'h0, 4'hF);
        chk("wr ro", {psld_pkg::RESP_OKAY, 32'h0}, {r, 32'h0});
        tc(20'h80000, 7'h7F, 7'h00);
        tc(20'h40000, 7'h40, 7'h00);
        tc(20'h20000, 7'h00, 7'h40);
        tc(20'h02000, 7'h10, 7'h60);
        tc(20'h10000, 7'h20, 7'h00);
        tc(20'h18000, 7'h00, 7'h28);
        tc(20'h04000, 7'h10, 7'h00);
        tc(20'h00400, 7'h10, 7'h00);
        tc(20'h00200, 7'h10, 7'h00);
        tc(20'h00100, 7'h00, 7'h08);
        tc(20'h00080, 7'h00, 7'h08);
        tc(20'h00040, 7'h08, 7'h00);
        tc(20'h00140, 7'h00, 7'h08);
        tc(20'h40020, 7'h44, 7'h00);
        tc(20'h10020, 7'h24, 7'h00);
        tc(20'h00010, 7'h00, 7'h04);
        tc(20'h40030, 7'h40, 7'h04);
        tc(20'h00008, 7'h00, 7'h02);
        tc(20'h00004, 7'h00, 7'h01);
        tc(20'h00002, 7'h00, 7'h01);
        tc(20'h00001, 7'h00, 7'h01);
        tc(20'h00000, 7'h00, 7'h00);
        bus(1'b1, psld_pkg::CTRL_OFF, 32'h0, 4'hF);
        chk("wr ctrl", {psld_pkg::RESP_OKAY, 32'h0}, {r, 32'h0});
        bus(1'b0, psld_pkg::CTRL_OFF, 32'h0, 4'h0);
        chk("ctrl old", {psld_pkg::RESP_OKAY, 32'h0}, {r, q});
        per = LEG;
        tc(20'h40000, 7'h40, 7'h00);
        tc(20'h20000, 7'h00, 7'h00);
        tc(20'h10000, 7'h20, 7'h00);
        tc(20'h12000, 7'h00, 7'h00);
        tc(20'h04000, 7'h10, 7'h00);
        tc(20'h00800, 7'h00, 7'h10);
        tc(20'h01000, 7'h00, 7'h10);
        tc(20'h08000, 7'h08, 7'h00);
        tc(20'h00100, 7'h08, 7'h00);
        tc(20'h00080, 7'h00, 7'h08);
        tc(20'h00040, 7'h00, 7'h08);
        tc(20'h00140, 7'h00, 7'h08);
        tc(20'h40010, 7'h44, 7'h00);
        tc(20'h10020, 7'h24, 7'h00);
        tc(20'h00004, 7'h00, 7'h01);
        tc(20'h00002, 7'h00, 7'h01);
        tc(20'h00001, 7'h00, 7'h00);
        tc(20'h00008, 7'h00, 7'h02);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        tc(20'h80000, 7'h7F, 7'h00);
        bus(1'b0, psld_pkg::INPUTS_OFF, 32'h0, 4'h0);
        chk("inputs", {14'h0, BASE ^ 20'h80000}, {r, q});
        bus(1'b0, psld_pkg::STATUS_OFF, 32'h0, 4'h0);
        chk("status", {26'h0, 8'h7F}, {r, q & 32'h7F});
        results();
    end
endmodule : testbench

bind psld_program_status_led_driver psld_checker #(
    .SLOW_BLINK_CYCLES(SLOW_BLINK_CYCLES),
    .LEGACY_BLINK_CYCLES(LEGACY_BLINK_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .ctrl(ctrl), .axiReq(axiReq),
    .axiRsp(axiRsp), .leds(leds)
);
